// ===== hw/vic_pkg.sv
/*
 * Constants of the interrupt controller: register offsets, field
 * positions, reset values and identity fields.
 * Assumes nothing of its surroundings.
 */
package vic_pkg;
	localparam int          VIC_NSRC      = 4;
	localparam int          VIC_CNT_W     = 20;
	// Register offsets (byte addresses)
	localparam logic [7:0]  VIC_OFS_IDENT = 8'h04;
	localparam logic [7:0]  VIC_OFS_CFG   = 8'h08;
	localparam logic [7:0]  VIC_OFS_CTL   = 8'h0C;
	// Identity fields; values are arbitrary
	localparam logic [15:0] VIC_MODULE_ID = 16'hC0DE;
	localparam logic [7:0]  VIC_REV_MAJOR = 8'h5A;
	localparam logic [7:0]  VIC_REV_MINOR = 8'h3C;
	// Configuration fields
	localparam int          VIC_CFG_MODE  = 12;
	localparam int          VIC_CFG_GEN   = 11;
	localparam int          VIC_CFG_LVL   = 8;
	localparam logic [31:0] VIC_CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] VIC_CFG_WMASK = 32'h0000_1EFF;
	// Control fields
	localparam int          VIC_CTL_EN    = 0;
	localparam int          VIC_CTL_DIS   = 16;
	localparam int          VIC_CTL_CLR   = 20;
	localparam int          VIC_CTL_INT   = 26;
	localparam int          VIC_CTL_VME   = 27;
	localparam int          VIC_CTL_STAT  = 28;
endpackage : vic_pkg

// ===== hw/vic_acq_if.sv
/*
 * Carrier between the controller and its acquisition event tracker.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface vic_acq_if;
	import vic_pkg::*;
	logic                 arm;
	logic                 event_end;
	logic                 multi;
	logic [VIC_CNT_W-1:0] max_events;
	logic                 src0_set;
	logic                 src1_set;
	logic                 armed;
	modport ctl (output arm, event_end, multi, max_events,
		input src0_set, src1_set, armed);
	modport trk (input arm, event_end, multi, max_events,
		output src0_set, src1_set, armed);
endinterface : vic_acq_if
`default_nettype wire

// ===== hw/vic_irq_source.sv
/*
 * One interrupt source: enable latch and pending flag.
 * Assumes write strobes are one-cycle pulses in the clk_in domain.
 */
`timescale 1ns/1ns
`default_nettype none
module vic_irq_source (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// Event and software strobes
	input  wire logic event_in,
	input  wire logic en_wr_in,
	input  wire logic dis_wr_in,
	input  wire logic clr_wr_in,
	input  wire logic ack_rel_in,
	// State
	output var  logic enable_out,
	output var  logic flag_out
);
	// Disable or release wins over a simultaneous enable
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			enable_out <= 1'b0;
		end else if (dis_wr_in || ack_rel_in) begin
			enable_out <= 1'b0;
		end else if (en_wr_in) begin
			enable_out <= 1'b1;
		end
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flag_out <= 1'b0;
		end else if (event_in) begin
			flag_out <= 1'b1;
		end else if (clr_wr_in || ack_rel_in) begin
			flag_out <= 1'b0;
		end
	end

	property p_set_wins;
		@(posedge clk_in) disable iff (rst_in)
		event_in |=> flag_out;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
endmodule : vic_irq_source
`default_nettype wire

// ===== hw/vic_event_tracker.sv
/*
 * Armed state and event count; raises source 0 per event end and
 * source 1 when sampling disarms.
 * Assumes arm and event end are one-cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none
module vic_event_tracker
	import vic_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// Carrier
	vic_acq_if.trk    acq
);
	logic [VIC_CNT_W-1:0] cnt_q;
	logic [VIC_CNT_W-1:0] cnt_d;
	logic                 last;

	assign cnt_d = cnt_q + VIC_CNT_W'(1);
	// A limit of zero ends multi-event on the first event
	assign last  = !acq.multi || (cnt_d >= acq.max_events);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			acq.armed <= 1'b0;
		end else if (acq.arm) begin
			acq.armed <= 1'b1;
		end else if (acq.event_end && acq.armed && last) begin
			acq.armed <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || acq.arm) begin
			cnt_q <= '0;
		end else if (acq.event_end && acq.armed) begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			acq.src0_set <= 1'b0;
			acq.src1_set <= 1'b0;
		end else begin
			acq.src0_set <= acq.event_end;
			acq.src1_set <= acq.event_end && acq.armed && last && !acq.arm;
		end
	end

	property p_stay_armed;
		@(posedge clk_in) disable iff (rst_in)
		acq.armed && acq.multi && acq.event_end && (cnt_d < acq.max_events)
			|=> acq.armed && !acq.src1_set;
	endproperty
	a_stay_armed: assert property (p_stay_armed) else $error("disarmed before last event");
endmodule : vic_event_tracker
`default_nettype wire

// ===== hw/vic_interrupt_control.sv
/*
 * Interrupt controller with identification word, configuration and
 * source control registers, and an interrupter answering acknowledge.
 * Assumes a synchronous register port with one-cycle read and write
 * strobes, and acknowledge cycles decoded to a one-cycle pulse.
 */
// Notes on behaviour
// - Identity word: module id in 31:16, major 15:8, minor 7:0.
// - Source 0 is raised whenever an acquisition event ends.
// - Source 1 is raised at disarm; sources 2 and 3 never assert.
// - Acts as interrupter returning an 8-bit vector on acknowledge.
// - Configuration bits 7:0 are the vector driven on D7..D0.
// - Register-access release: request holds until disable or clear written; host re-enables.
// - Acknowledge release: acknowledge clears flag and disables source; host re-enables.
// - Configuration bit 12 selects release: 0 register access, 1 acknowledge.
// - Request asserted only while configuration bit 11 is set.
// - Request level from configuration bits 10:8, bit 8 always 0.
// - Writing 1 to control 3:0 enables sources; read returns enables.
// - Writing 1 to control 19:16 disables sources; reads as 0.
// - Writing 1 to control 23:20 clears flags; read returns flags.
// - Control 31:28 read source status, sources 3 down to 0.
// - Multi-event: armed clears only after last event, with source 1.
`timescale 1ns/1ns
`default_nettype none
module vic_interrupt_control
	import vic_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Register port
	input  wire logic [7:0]           reg_addr_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [31:0]          reg_wdata_in,
	output var  logic [31:0]          reg_rdata_out,
	output var  logic                 reg_ack_out,
	// Interrupt request and acknowledge
	output var  logic                 irq_req_out,
	output var  logic [2:0]           irq_level_out,
	input  wire logic                 iack_in,
	input  wire logic [2:0]           iack_level_in,
	output var  logic [7:0]           iack_data_out,
	output var  logic                 iack_dtack_out,
	// Acquisition events
	input  wire logic                 arm_in,
	input  wire logic                 event_end_in,
	input  wire logic                 multi_event_in,
	input  wire logic [VIC_CNT_W-1:0] max_events_in,
	output var  logic                 armed_out
);
	// ----------------------------------------------------------------
	// Decode and state
	// ----------------------------------------------------------------
	logic [31:0]          cfg_q;
	logic [VIC_NSRC-1:0]  enable;
	logic [VIC_NSRC-1:0]  flag;
	logic [VIC_NSRC-1:0]  status;
	logic [VIC_NSRC-1:0]  events;
	logic [VIC_NSRC-1:0]  en_wr;
	logic [VIC_NSRC-1:0]  dis_wr;
	logic [VIC_NSRC-1:0]  clr_wr;
	logic [VIC_NSRC-1:0]  ack_rel;
	logic                 int_req;
	logic                 vme_req;
	logic                 ctl_wr;
	logic                 ack_hit;
	logic [31:0]          ctl_read;
	logic [31:0]          rdata_d;

	vic_acq_if acq ();

	assign acq.arm        = arm_in;
	assign acq.event_end  = event_end_in;
	assign acq.multi      = multi_event_in;
	assign acq.max_events = max_events_in;

	assign ctl_wr = reg_wr_in && (reg_addr_in == VIC_OFS_CTL);
	assign en_wr  = ctl_wr ? reg_wdata_in[VIC_CTL_EN +: VIC_NSRC] : '0;
	assign dis_wr = ctl_wr ? reg_wdata_in[VIC_CTL_DIS +: VIC_NSRC] : '0;
	assign clr_wr = ctl_wr ? reg_wdata_in[VIC_CTL_CLR +: VIC_NSRC] : '0;

	// Reserved sources are tied off
	assign events = {2'b00, acq.src1_set, acq.src0_set};

	assign status  = flag & enable;
	assign int_req = |status;
	assign vme_req = int_req && cfg_q[VIC_CFG_GEN];

	// Only a pending request at the level being acknowledged is answered
	assign ack_hit = iack_in && irq_req_out && (iack_level_in == irq_level_out);
	// Release on acknowledge drops exactly the sources then pending
	assign ack_rel = (ack_hit && cfg_q[VIC_CFG_MODE]) ? status : '0;

	// ----------------------------------------------------------------
	// Sources and event tracker
	// ----------------------------------------------------------------
	for (genvar i = 0; i < VIC_NSRC; i++) begin : g_src
		vic_irq_source u_src (
			.clk_in     (clk_in),
			.rst_in     (rst_in),
			.event_in   (events[i]),
			.en_wr_in   (en_wr[i]),
			.dis_wr_in  (dis_wr[i]),
			.clr_wr_in  (clr_wr[i]),
			.ack_rel_in (ack_rel[i]),
			.enable_out (enable[i]),
			.flag_out   (flag[i])
		);
	end

	vic_event_tracker u_trk (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.acq    (acq)
	);

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	// Level bit 0 and bits above 12 are never stored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_q <= VIC_CFG_RST;
		end else if (reg_wr_in && (reg_addr_in == VIC_OFS_CFG)) begin
			cfg_q <= reg_wdata_in & VIC_CFG_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		ctl_read = '0;
		ctl_read[VIC_CTL_EN +: VIC_NSRC]   = enable;
		ctl_read[VIC_CTL_CLR +: VIC_NSRC]  = flag;
		ctl_read[VIC_CTL_INT]              = int_req;
		ctl_read[VIC_CTL_VME]              = vme_req;
		ctl_read[VIC_CTL_STAT +: VIC_NSRC] = status;
	end

	always_comb begin
		unique case (reg_addr_in)
			VIC_OFS_IDENT: rdata_d = {VIC_MODULE_ID, VIC_REV_MAJOR, VIC_REV_MINOR};
			VIC_OFS_CFG:   rdata_d = cfg_q;
			VIC_OFS_CTL:   rdata_d = ctl_read;
			default:       rdata_d = '0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
			reg_ack_out   <= 1'b0;
		end else begin
			reg_ack_out <= reg_rd_in || reg_wr_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// Request and acknowledge
	// ----------------------------------------------------------------
	// Level follows the register even while idle; host keeps it to 2, 4, 6
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_req_out   <= 1'b0;
			irq_level_out <= '0;
		end else begin
			irq_req_out   <= vme_req && !(|ack_rel);
			irq_level_out <= cfg_q[VIC_CFG_LVL +: 3];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			iack_data_out  <= '0;
			iack_dtack_out <= 1'b0;
		end else begin
			iack_dtack_out <= ack_hit;
			if (ack_hit) begin
				iack_data_out <= cfg_q[7:0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			armed_out <= 1'b0;
		end else begin
			armed_out <= acq.armed;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_ident;
		@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && (reg_addr_in == VIC_OFS_IDENT)
			|=> reg_ack_out && (reg_rdata_out[31:16] == VIC_MODULE_ID)
			&& (reg_rdata_out[15:0] == {VIC_REV_MAJOR, VIC_REV_MINOR});
	endproperty
	a_ident: assert property (p_ident) else $error("identity word wrong");

	property p_src0;
		@(posedge clk_in) disable iff (rst_in)
		event_end_in |-> ##2 flag[0];
	endproperty
	a_src0: assert property (p_src0) else $error("event end did not flag source 0");

	property p_reserved;
		@(posedge clk_in) disable iff (rst_in)
		flag[3:2] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved source flagged");

	property p_vector;
		@(posedge clk_in) disable iff (rst_in)
		ack_hit |=> iack_dtack_out && (iack_data_out == $past(cfg_q[7:0]));
	endproperty
	a_vector: assert property (p_vector) else $error("vector not returned");

	property p_rora_hold;
		@(posedge clk_in) disable iff (rst_in)
		!cfg_q[VIC_CFG_MODE] && status[0] && !dis_wr[0] && !clr_wr[0] |=> status[0];
	endproperty
	a_rora_hold: assert property (p_rora_hold) else $error("request released early");

	property p_roak;
		@(posedge clk_in) disable iff (rst_in)
		ack_hit && cfg_q[VIC_CFG_MODE] && status[0] |=> !enable[0] && !irq_req_out;
	endproperty
	a_roak: assert property (p_roak) else $error("acknowledge did not release");

	property p_gen;
		@(posedge clk_in) disable iff (rst_in)
		irq_req_out |-> $past(cfg_q[VIC_CFG_GEN]) && $past(int_req);
	endproperty
	a_gen: assert property (p_gen) else $error("request without global enable");

	property p_level;
		@(posedge clk_in) disable iff (rst_in)
		!irq_level_out[0] && !cfg_q[VIC_CFG_LVL];
	endproperty
	a_level: assert property (p_level) else $error("level bit 0 set");

	property p_ctl_zero;
		@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && (reg_addr_in == VIC_OFS_CTL)
			|=> (reg_rdata_out[19:16] == 4'h0) && (reg_rdata_out[25:24] == 2'h0)
			&& (reg_rdata_out[15:4] == 12'h000);
	endproperty
	a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits set");

	property p_status;
		@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && (reg_addr_in == VIC_OFS_CTL)
			|=> reg_rdata_out[31:28] == $past(flag & enable);
	endproperty
	a_status: assert property (p_status) else $error("status bits wrong");

	property p_enable_wr;
		@(posedge clk_in) disable iff (rst_in)
		en_wr[0] && !dis_wr[0] && !ack_rel[0] |=> enable[0];
	endproperty
	a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");

	property p_disable_wr;
		@(posedge clk_in) disable iff (rst_in)
		dis_wr[0] |=> !enable[0];
	endproperty
	a_disable_wr: assert property (p_disable_wr) else $error("disable write lost");

	// A clear that meets a new event loses, so only a quiet clear is checked
	property p_clear_wr;
		@(posedge clk_in) disable iff (rst_in)
		clr_wr[1] && !events[1] |=> !flag[1];
	endproperty
	a_clear_wr: assert property (p_clear_wr) else $error("flag clear lost");

	property p_src1;
		@(posedge clk_in) disable iff (rst_in)
		event_end_in && acq.armed && !multi_event_in && !arm_in |-> ##2 flag[1];
	endproperty
	a_src1: assert property (p_src1) else $error("disarm did not flag source 1");

	property p_disarm;
		@(posedge clk_in) disable iff (rst_in)
		event_end_in && acq.armed && !multi_event_in && !arm_in |=> !acq.armed;
	endproperty
	a_disarm: assert property (p_disarm) else $error("single event did not disarm");

	property p_ack_refused;
		@(posedge clk_in) disable iff (rst_in)
		iack_in && (iack_level_in != irq_level_out) |=> !iack_dtack_out;
	endproperty
	a_ack_refused: assert property (p_ack_refused) else $error("wrong level answered");

	property p_req_gate;
		@(posedge clk_in) disable iff (rst_in)
		!cfg_q[VIC_CFG_GEN] |=> !irq_req_out;
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("request while gated off");
endmodule : vic_interrupt_control
`default_nettype wire

// ===== tb/vic_host_model.sv
/*
 * Host CPU model: answers a pending request with one acknowledge.
 * Assumes the controller's registered request and a single clock.
 */
`timescale 1ns/1ns
`default_nettype none
module vic_host_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Test control
	input  wire logic       ack_on_in,
	input  wire logic       bad_lvl_in,
	input  wire logic [3:0] delay_in,
	// Controller side
	input  wire logic       irq_req_in,
	input  wire logic [2:0] irq_level_in,
	input  wire logic       dtack_in,
	input  wire logic [7:0] data_in,
	output var  logic       iack_out,
	output var  logic [2:0] iack_level_out,
	output var  logic [7:0] vec_out,
	output var  int         n_ack_out
);
	// ----------------------------------------
	// Acknowledge cycle
	// ----------------------------------------
	initial begin
		iack_out = 1'b0;
		iack_level_out = 3'h0;
		vec_out = 8'h00;
		n_ack_out = 0;
	end
	always begin
		@(posedge clk_in);
		if (!rst_in && ack_on_in && irq_req_in) begin
			repeat (delay_in) @(posedge clk_in);
			iack_out       <= 1'b1;
			iack_level_out <= bad_lvl_in ? irq_level_in ^ 3'h4 : irq_level_in;
			@(posedge clk_in);
			iack_out       <= 1'b0;
			// Released lines never keep the last value
			iack_level_out <= ~iack_level_out;
			#1;
			if (dtack_in === 1'b1) begin
				n_ack_out <= n_ack_out + 1;
				vec_out   <= data_in;
			end
			// One answer per request, as a real handler services once
			while (irq_req_in === 1'b1 && ack_on_in) @(posedge clk_in);
		end
	end
endmodule : vic_host_model
`default_nettype wire

// ===== tb/vic_interrupt_control_test.sv
/*
 * Self-checking bench of the interrupt controller with a host model.
 * Assumes the package constants and the registered strobe port.
 */
`timescale 1ns/1ns
`default_nettype none
module vic_interrupt_control_test;
	import vic_pkg::*;
	logic                 clk_in, rst_in, reg_wr_in, reg_rd_in, reg_ack_out;
	logic [7:0]           reg_addr_in, iack_data_out, host_vec;
	logic [31:0]          reg_wdata_in, reg_rdata_out;
	logic                 irq_req_out, iack_in, iack_dtack_out, arm_in;
	logic [2:0]           irq_level_out, iack_level_in;
	logic                 event_end_in, multi_event_in, armed_out;
	logic [VIC_CNT_W-1:0] max_events_in;
	logic                 ack_on, bad_lvl;
	logic [3:0]           ack_dly;
	int                   host_n, n_mismatch, comparisons, cycles;

	vic_interrupt_control dut_u (.clk_in(clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.reg_ack_out(reg_ack_out), .irq_req_out(irq_req_out),
		.irq_level_out(irq_level_out), .iack_in(iack_in),
		.iack_level_in(iack_level_in), .iack_data_out(iack_data_out),
		.iack_dtack_out(iack_dtack_out), .arm_in(arm_in),
		.event_end_in(event_end_in), .multi_event_in(multi_event_in),
		.max_events_in(max_events_in), .armed_out(armed_out));
	vic_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .ack_on_in(ack_on),
		.bad_lvl_in(bad_lvl), .delay_in(ack_dly), .irq_req_in(irq_req_out),
		.irq_level_in(irq_level_out), .dtack_in(iack_dtack_out),
		.data_in(iack_data_out), .iack_out(iack_in),
		.iack_level_out(iack_level_in), .vec_out(host_vec), .n_ack_out(host_n));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
		#1;
		chk({31'h0, reg_ack_out}, 32'h1);
		chk(reg_rdata_out, exp);
	endtask : rd
	task automatic pulse(input logic ev);
		@(posedge clk_in);
		if (ev) event_end_in <= 1'b1;
		else arm_in <= 1'b1;
		@(posedge clk_in);
		event_end_in <= 1'b0;
		arm_in       <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
	endtask : pulse
	task automatic wait_ack(input int n);
		repeat (40) if (host_n < n) @(posedge clk_in);
		#2;
		chk(host_n, n);
	endtask : wait_ack

	// ----------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial cycles = 0;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		{reg_wr_in, reg_rd_in, arm_in, event_end_in, multi_event_in} = 5'h00;
		{ack_on, bad_lvl, ack_dly, reg_addr_in, reg_wdata_in} = '0;
		max_events_in = '0;
		n_mismatch = 0;
		comparisons = 0;
		rst_in = 1'b1;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(VIC_OFS_CFG, VIC_CFG_RST);
		rd(VIC_OFS_CTL, 32'h0000_0000);
		wr(VIC_OFS_IDENT, 32'h0000_0000);
		rd(VIC_OFS_IDENT, {VIC_MODULE_ID, VIC_REV_MAJOR, VIC_REV_MINOR});
		rd(8'h10, 32'h0000_0000);
		wr(VIC_OFS_CFG, 32'hFFFF_FFFF);
		rd(VIC_OFS_CFG, 32'h0000_1EFF);
		// Odd levels break the host's side on purpose: bit 0 must drop
		for (int l = 2; l < 8; l++) begin
			wr(VIC_OFS_CFG, 32'(l) << VIC_CFG_LVL);
			@(posedge clk_in);
			#1;
			chk({29'h0, irq_level_out}, 32'(l & 6));
		end
		wr(VIC_OFS_CTL, 32'h0000_000F);
		rd(VIC_OFS_CTL, 32'h0000_000F);
		wr(VIC_OFS_CTL, 32'h0005_000F);
		rd(VIC_OFS_CTL, 32'h0000_000A);
		wr(VIC_OFS_CTL, 32'h000E_0001);
		// Register-access release
		wr(VIC_OFS_CFG, 32'h0000_0AA5);
		pulse(1'b0);
		pulse(1'b1);
		chk({31'h0, armed_out}, 32'h0);
		rd(VIC_OFS_CTL, 32'h1C30_0001);
		ack_on <= 1'b1;
		wait_ack(1);
		chk({24'h0, host_vec}, 32'h0000_00A5);
		chk({31'h0, irq_req_out}, 32'h1);
		wr(VIC_OFS_CTL, 32'h0001_0000);
		@(posedge clk_in);
		#1;
		chk({31'h0, irq_req_out}, 32'h0);
		wr(VIC_OFS_CTL, 32'h00F0_0001);
		rd(VIC_OFS_CTL, 32'h0000_0001);
		// Global gate, then an acknowledge at the wrong level
		wr(VIC_OFS_CFG, 32'h0000_02A5);
		pulse(1'b0);
		pulse(1'b1);
		rd(VIC_OFS_CTL, 32'h1430_0001);
		chk({31'h0, irq_req_out}, 32'h0);
		bad_lvl <= 1'b1;
		wr(VIC_OFS_CFG, 32'h0000_0AA5);
		repeat (12) @(posedge clk_in);
		chk(host_n, 1);
		ack_on  <= 1'b0;
		bad_lvl <= 1'b0;
		// Acknowledge release, answered slowly
		wr(VIC_OFS_CFG, 32'h0000_1A5A);
		ack_dly <= 4'h5;
		ack_on  <= 1'b1;
		wait_ack(2);
		chk({24'h0, host_vec}, 32'h0000_005A);
		chk({31'h0, irq_req_out}, 32'h0);
		rd(VIC_OFS_CTL, 32'h0020_0000);
		ack_on <= 1'b0;
		// Multi-event: disarm on the third event only
		wr(VIC_OFS_CTL, 32'h00F0_0002);
		multi_event_in <= 1'b1;
		max_events_in  <= 20'h3;
		pulse(1'b0);
		pulse(1'b1);
		pulse(1'b1);
		chk({31'h0, armed_out}, 32'h1);
		rd(VIC_OFS_CTL, 32'h0010_0002);
		pulse(1'b1);
		chk({31'h0, armed_out}, 32'h0);
		rd(VIC_OFS_CTL, 32'h2C30_0002);
		close_out();
	end
endmodule : vic_interrupt_control_test
`default_nettype wire
